// ===== design/dcs_clock_ctrl.sv
// Clock selection and loop synthesiser control of the converter
// Operation
// - Path select low bypasses the loop; sample clock is the input clock.
// - Sleep bit high puts loop and oscillator to sleep.
// - Path select high takes sample clock from the loop output.
// - Sleep bit low enables loop and oscillator.
// - Loop mode multiplies the reference up to the sample rate.
// - Prescaler codes 111,110,101,100 divide by 8,6,5,4.
// - M field is the binary divide; comparator rate is sample clock over M.
// - N divider lets the comparator run below reference frequency.
// - Ratios below 120 are stable with the internal filter alone.
// - Charge pump code 01 gives single, 11 double current.
// - Coarse tune moves oscillator centre toward P times sample rate.
// - Three-bit lock status readable; software retunes when out of range.
// - Loop mode makes the output strobe from the N divider output.
// - Cores run on converter clock; input receivers on data clock.
`timescale 1ns/1ps
`default_nettype none
module dcs_clock_ctrl
    import dcs_pkg::*;
(
    input  wire logic                  core_clk_in,
    input  wire logic                  rst_in,
    input  wire logic                  path_sel_in,
    input  wire logic                  sleep_in,
    input  wire logic [PRESCALE_W-1:0] prescale_sel_in,
    input  wire logic [MDIV_W-1:0]     m_div_in,
    input  wire logic [CP_W-1:0]       charge_pump_sel_in,
    input  wire logic [TUNE_W-1:0]     coarse_tune_in,
    input  wire logic                  ext_filter_in,
    input  wire logic                  vco_low_in,
    input  wire logic                  vco_high_in,
    output var  logic                  use_loop_clk_out,
    output var  logic                  loop_enable_out,
    output var  logic [3:0]            vco_divide_out,
    output var  logic [1:0]            cp_current_out,
    output var  logic [TUNE_W-1:0]     vco_tune_out,
    output var  logic [LOCK_W-1:0]     lock_status_out,
    output var  logic                  ratio_ok_out,
    output var  logic                  stable_cfg_out,
    output var  logic                  output_strobe_out,
    output var  logic                  cfg_changed_out
);
    // Synchronised pin inputs, registered configuration fields and lock-watch state
    logic       path_s1_q, path_s2_q, sleep_s1_q, sleep_s2_q;
    logic       low_s1_q, low_s2_q, high_s1_q, high_s2_q;
    logic [2:0]  p_q;
    logic [7:0]  m_q;
    logic [1:0]  cp_q;
    logic [5:0]  tune_q;
    logic        ext_q;
    dcs_state_t  state_q, state_d;
    logic [7:0]  settle_q, settle_d;
    logic        strobe_tick;

    // Two flops on the path, sleep and out-of-range pins before any logic reads them
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            path_s1_q  <= RST_PATH_SEL;
            path_s2_q  <= RST_PATH_SEL;
            sleep_s1_q <= RST_SLEEP;
            sleep_s2_q <= RST_SLEEP;
            low_s1_q   <= 1'b0;
            low_s2_q   <= 1'b0;
            high_s1_q  <= 1'b0;
            high_s2_q  <= 1'b0;
        end else begin
            path_s1_q  <= path_sel_in;
            path_s2_q  <= path_s1_q;
            sleep_s1_q <= sleep_in;
            sleep_s2_q <= sleep_s1_q;
            low_s1_q   <= vco_low_in;
            low_s2_q   <= low_s1_q;
            high_s1_q  <= vco_high_in;
            high_s2_q  <= high_s1_q;
        end
    end

    // Configuration fields are static while software changes them
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            p_q    <= PRESCALE_DIV4;
            m_q    <= RST_MDIV;
            cp_q   <= CP_SINGLE;
            tune_q <= RST_TUNE;
            ext_q  <= 1'b0;
        end else begin
            p_q    <= prescale_sel_in;
            m_q    <= m_div_in;
            cp_q   <= charge_pump_sel_in;
            tune_q <= coarse_tune_in;
            ext_q  <= ext_filter_in;
        end
    end

    // Ratio checks on P times M
    logic [3:0]  p_val;
    logic [11:0] ratio;
    logic        ratio_ok, stable_cfg, cfg_change, loop_on;
    assign p_val      = dcs_prescale(p_q);
    // Widen both factors first so the product cannot wrap at eight bits
    assign ratio      = 12'(p_val) * 12'(m_q);
    assign ratio_ok   = (ratio >= RATIO_MIN) && (ratio <= RATIO_MAX);
    // Internal filter suffices below 120; above needs help
    assign stable_cfg = (ratio < RATIO_STABLE) ||
                        (cp_q == CP_DOUBLE) || ext_q;
    assign cfg_change = (p_q != prescale_sel_in) || (m_q != m_div_in) ||
                        (cp_q != charge_pump_sel_in) ||
                        (tune_q != coarse_tune_in);
    assign loop_on    = !sleep_s2_q;

    // Lock watch: restart settling on any change of prescale, M, pump or tune
    always_comb begin
        state_d  = state_q;
        settle_d = settle_q;
        unique case (state_q)
            DCS_SLEEP: begin
                settle_d = 8'h00;
                if (loop_on) begin
                    state_d = DCS_SETTLE;
                end
            end
            DCS_SETTLE: begin
                settle_d = settle_q + 8'h01;
                if (!loop_on) begin
                    state_d = DCS_SLEEP;
                end else if (cfg_change) begin
                    settle_d = 8'h00;
                end else if (settle_q >= LOCK_SETTLE) begin
                    state_d = DCS_RUN;
                end
            end
            DCS_RUN: begin
                if (!loop_on) begin
                    state_d = DCS_SLEEP;
                end else if (cfg_change) begin
                    state_d  = DCS_SETTLE;
                    settle_d = 8'h00;
                end
            end
            default: begin
                state_d  = DCS_SLEEP;
                settle_d = 8'h00;
            end
        endcase
    end

    // Lock code: sleep, out of range low or high, or locked
    logic [2:0] lock_d;
    assign lock_d = (state_q == DCS_SLEEP) ? LOCK_SLEEP :
                    low_s2_q               ? LOCK_LOW   :
                    high_s2_q              ? LOCK_HIGH  :
                    (state_q == DCS_RUN)   ? LOCK_OK    : LOCK_LOW;

    // Comparator-rate divider; runs only with the loop selected and awake
    dcs_divider u_ndiv (
        .clk_in   (core_clk_in),
        .rst_in   (rst_in),
        .run_in   (loop_on && path_s2_q),
        .div_in   (m_q),
        .tick_out (strobe_tick)
    );

    // Registered outputs
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            state_q           <= DCS_SLEEP;
            settle_q          <= 8'h00;
            use_loop_clk_out  <= RST_PATH_SEL;
            loop_enable_out   <= 1'b0;
            vco_divide_out    <= PRESCALE_VAL4;
            cp_current_out    <= CP_SINGLE;
            vco_tune_out      <= RST_TUNE;
            lock_status_out   <= LOCK_SLEEP;
            ratio_ok_out      <= 1'b0;
            stable_cfg_out    <= 1'b0;
            output_strobe_out <= 1'b0;
            cfg_changed_out   <= 1'b0;
        end else begin
            state_q           <= state_d;
            settle_q          <= settle_d;
            // Mux select for the sample-rate clock (cores on this clock)
            use_loop_clk_out  <= path_s2_q;
            loop_enable_out   <= loop_on;
            vco_divide_out    <= p_val;
            cp_current_out    <= (cp_q == CP_DOUBLE) ? CP_DOUBLE :
                                 (cp_q == CP_SINGLE) ? CP_SINGLE : CP_OFF;
            vco_tune_out      <= tune_q;
            lock_status_out   <= lock_d;
            ratio_ok_out      <= ratio_ok;
            stable_cfg_out    <= stable_cfg;
            // Strobe only in loop mode; bypass needs the external one
            output_strobe_out <= strobe_tick && path_s2_q;
            cfg_changed_out   <= cfg_change;
        end
    end
endmodule : dcs_clock_ctrl
`default_nettype wire

// ===== design/dcs_pkg.sv
// Package: constants and types of the converter clock synthesiser control
package dcs_pkg;
    // Control field widths
    localparam int PRESCALE_W = 3;
    localparam int MDIV_W     = 8;
    localparam int CP_W       = 2;
    localparam int TUNE_W     = 6;
    localparam int LOCK_W     = 3;
    // Prescaler codes and divide values
    localparam logic [2:0] PRESCALE_DIV8 = 3'h7;
    localparam logic [2:0] PRESCALE_DIV6 = 3'h6;
    localparam logic [2:0] PRESCALE_DIV5 = 3'h5;
    localparam logic [2:0] PRESCALE_DIV4 = 3'h4;
    localparam logic [3:0] PRESCALE_VAL8 = 4'h8;
    localparam logic [3:0] PRESCALE_VAL6 = 4'h6;
    localparam logic [3:0] PRESCALE_VAL5 = 4'h5;
    localparam logic [3:0] PRESCALE_VAL4 = 4'h4;
    // Charge pump codes
    localparam logic [1:0] CP_OFF    = 2'h0;
    localparam logic [1:0] CP_SINGLE = 2'h1;
    localparam logic [1:0] CP_DOUBLE = 2'h3;
    // Loop ratio limits (P times M)
    localparam logic [11:0] RATIO_MIN    = 12'h018;
    localparam logic [11:0] RATIO_MAX    = 12'h1E0;
    localparam logic [11:0] RATIO_STABLE = 12'h078;
    // Lock status codes
    localparam logic [2:0] LOCK_SLEEP = 3'h0;
    localparam logic [2:0] LOCK_LOW   = 3'h1;
    localparam logic [2:0] LOCK_OK    = 3'h3;
    localparam logic [2:0] LOCK_HIGH  = 3'h7;
    // Reset values
    localparam logic       RST_PATH_SEL  = 1'b0;
    localparam logic       RST_SLEEP     = 1'b1;
    localparam logic [7:0] RST_MDIV      = 8'h04;
    localparam logic [5:0] RST_TUNE      = 6'h20;
    // Lock watch window, in cycles of the sample-rate clock
    localparam logic [7:0] LOCK_SETTLE   = 8'h40;

    typedef enum logic [2:0] {
        DCS_SLEEP  = 3'b001,
        DCS_SETTLE = 3'b010,
        DCS_RUN    = 3'b100
    } dcs_state_t;

    // Divide value of a prescaler code; unused codes act as divide-by-4
    function automatic logic [3:0] dcs_prescale(input logic [2:0] code);
        unique case (code)
            PRESCALE_DIV8: dcs_prescale = PRESCALE_VAL8;
            PRESCALE_DIV6: dcs_prescale = PRESCALE_VAL6;
            PRESCALE_DIV5: dcs_prescale = PRESCALE_VAL5;
            default:       dcs_prescale = PRESCALE_VAL4;
        endcase
    endfunction : dcs_prescale
endpackage : dcs_pkg

// ===== design/dcs_divider.sv
// Programmable divider: one pulse every div_in cycles
`timescale 1ns/1ps
`default_nettype none
module dcs_divider
    import dcs_pkg::*;
(
    input  wire logic              clk_in,
    input  wire logic              rst_in,
    input  wire logic              run_in,
    input  wire logic [MDIV_W-1:0] div_in,
    output var  logic              tick_out
);
    logic [MDIV_W-1:0] cnt_q;
    logic [MDIV_W-1:0] cnt_d;
    logic              wrap;

    // Divide by zero or one gives a pulse every cycle
    assign wrap  = (cnt_q + 8'h01 >= div_in);
    assign cnt_d = (!run_in || wrap) ? 8'h00 : cnt_q + 8'h01;

    // Count and emit the wrap pulse
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            cnt_q    <= 8'h00;
            tick_out <= 1'b0;
        end else begin
            cnt_q    <= cnt_d;
            tick_out <= run_in && wrap;
        end
    end
endmodule : dcs_divider
`default_nettype wire

// ===== tb/dcs_clock_ctrl_asserts.sv
// Port checker for the clock synthesiser control
`timescale 1ns/1ps
`default_nettype none
module dcs_clock_ctrl_asserts
    import dcs_pkg::*;
(
    input wire logic                  core_clk_in,
    input wire logic                  rst_in,
    input wire logic                  path_sel_in,
    input wire logic                  sleep_in,
    input wire logic [PRESCALE_W-1:0] prescale_sel_in,
    input wire logic [CP_W-1:0]       charge_pump_sel_in,
    input wire logic [TUNE_W-1:0]     coarse_tune_in,
    input wire logic [MDIV_W-1:0]     m_div_in,
    input wire logic                  use_loop_clk_out,
    input wire logic                  loop_enable_out,
    input wire logic [3:0]            vco_divide_out,
    input wire logic [1:0]            cp_current_out,
    input wire logic [TUNE_W-1:0]     vco_tune_out,
    input wire logic [LOCK_W-1:0]     lock_status_out,
    input wire logic                  output_strobe_out
);
    logic [2:0] up_q;
    logic [7:0] wait_q;
    wire        ready = up_q[2];
    // Pipes still hold pre-reset inputs, so checks wait four edges
    always_ff @(posedge core_clk_in or posedge rst_in)
        if (rst_in) up_q <= 3'h0;
        else if (!ready) up_q <= up_q + 3'h1;
    // Run of cycles spent settling
    always_ff @(posedge core_clk_in or posedge rst_in)
        if (rst_in) wait_q <= 8'h00;
        else if (lock_status_out != LOCK_LOW) wait_q <= 8'h00;
        else if (wait_q != 8'hFF) wait_q <= wait_q + 8'h01;
    default clocking @(posedge core_clk_in); endclocking
    default disable iff (rst_in);
    a_path_follow: assert property (
        ready |-> use_loop_clk_out == $past(path_sel_in, 3))
        else $error("clock path select wrong");
    a_sleep_follow: assert property (
        ready |-> loop_enable_out == !$past(sleep_in, 3))
        else $error("loop enable wrong");
    a_prescale_map: assert property (
        ready |-> vco_divide_out == ($past(prescale_sel_in, 2) == 3'h7 ? 4'h8 :
        {2'h1, $past(prescale_sel_in, 2) == 3'h6,
        $past(prescale_sel_in, 2) == 3'h5}))
        else $error("prescale divide wrong");
    a_cp_map: assert property (
        ready |-> cp_current_out == ($past(charge_pump_sel_in, 2) inside
        {2'h1, 2'h3} ? $past(charge_pump_sel_in, 2) : 2'h0))
        else $error("charge pump current wrong");
    a_tune_pass: assert property (
        ready |-> vco_tune_out == $past(coarse_tune_in, 2))
        else $error("coarse tune wrong");
    a_strobe_gap: assert property (
        output_strobe_out && $stable(m_div_in) && m_div_in >= 8'h04
        |=> (!output_strobe_out) [*3]) else $error("strobe too soon");
    a_strobe_loop: assert property (
        output_strobe_out |-> use_loop_clk_out && loop_enable_out)
        else $error("strobe outside loop mode");
    a_lock_sleep: assert property (
        ready && !$past(loop_enable_out) |-> lock_status_out == LOCK_SLEEP)
        else $error("lock status not sleep");
    a_lock_settle: assert property (
        lock_status_out == LOCK_OK && $past(lock_status_out) != LOCK_OK
        |-> $past(lock_status_out) == LOCK_LOW && wait_q >= 8'h3F)
        else $error("lock without settling");
endmodule : dcs_clock_ctrl_asserts
bind dcs_clock_ctrl dcs_clock_ctrl_asserts u_chk (.core_clk_in, .rst_in,
    .path_sel_in, .sleep_in, .prescale_sel_in, .charge_pump_sel_in,
    .coarse_tune_in, .m_div_in, .use_loop_clk_out, .loop_enable_out,
    .vco_divide_out, .cp_current_out, .vco_tune_out, .lock_status_out,
    .output_strobe_out);
`default_nettype wire

// ===== tb/dcs_vco_model.sv
// Oscillator range model driving the out-of-range flags
`timescale 1ns/1ps
`default_nettype none
module dcs_vco_model
    import dcs_pkg::*;
#(
    parameter logic [TUNE_W-1:0] TUNE_LO = 6'h10,
    parameter logic [TUNE_W-1:0] TUNE_HI = 6'h30
)(
    input  wire logic              clk_in,
    input  wire logic              enable_in,
    input  wire logic [TUNE_W-1:0] tune_in,
    output var  logic              low_out = 1'b0,
    output var  logic              high_out = 1'b0
);
    // Tune moves the centre; a sleeping detector flags neither side
    always @(posedge clk_in) begin
        low_out <= enable_in && tune_in < TUNE_LO;
        high_out <= enable_in && tune_in > TUNE_HI;
    end
endmodule : dcs_vco_model
`default_nettype wire

// ===== tb/tb_top.sv
// Self-checking bench for the clock synthesiser control
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin mismatches++; \
    $display("mismatch t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
    logic        core_clk_in = 1'b0;
    logic        rst_in, path_sel_in, sleep_in, ext_filter_in;
    logic        vco_low_in, vco_high_in, use_loop_clk_out, loop_enable_out;
    logic        ratio_ok_out, stable_cfg_out, output_strobe_out;
    logic        cfg_changed_out;
    logic [2:0]  prescale_sel_in, lock_status_out;
    logic [7:0]  m_div_in, n;
    logic [1:0]  charge_pump_sel_in, cp_current_out;
    logic [5:0]  coarse_tune_in, vco_tune_out;
    logic [3:0]  vco_divide_out;
    logic [17:0] r;
    logic [11:0] ratio;
    int          mismatches = 0;
    int          n_compared = 0;
    // Rows: prescale code, M, pump code, filter, expected divide
    localparam logic [17:0] ROWS [9] = '{{3'h7, 8'h04, 2'h1, 1'h0, 4'h8},
        {3'h6, 8'h08, 2'h3, 1'h0, 4'h6}, {3'h5, 8'h20, 2'h0, 1'h0, 4'h5},
        {3'h4, 8'h05, 2'h2, 1'h0, 4'h4}, {3'h0, 8'h04, 2'h1, 1'h0, 4'h4},
        {3'h7, 8'h3C, 2'h3, 1'h0, 4'h8}, {3'h7, 8'h3D, 2'h1, 1'h0, 4'h8},
        {3'h6, 8'h04, 2'h1, 1'h0, 4'h6}, {3'h5, 8'h20, 2'h0, 1'h1, 4'h5}};
    always #2 core_clk_in = ~core_clk_in;
    dcs_clock_ctrl i_dut (.core_clk_in, .rst_in, .path_sel_in, .sleep_in,
        .prescale_sel_in, .m_div_in, .charge_pump_sel_in, .coarse_tune_in,
        .ext_filter_in, .vco_low_in, .vco_high_in, .use_loop_clk_out,
        .loop_enable_out, .vco_divide_out, .cp_current_out, .vco_tune_out,
        .lock_status_out, .ratio_ok_out, .stable_cfg_out,
        .output_strobe_out, .cfg_changed_out);
    dcs_vco_model i_vco (.clk_in(core_clk_in), .enable_in(loop_enable_out),
        .tune_in(vco_tune_out), .low_out(vco_low_in), .high_out(vco_high_in));
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    // Settling takes tens of cycles, so the wait is bounded, not fixed
    task automatic wait_lock(input logic [2:0] v);
        int k;
        for (k = 0; k < 300 && lock_status_out !== v; k++)
            @(negedge core_clk_in);
        `CHK(lock_status_out, v)
        if (k == 300) tally_and_finish();
    endtask : wait_lock
    task automatic count_strobes(input int cyc);
        n = 8'h00;
        repeat (cyc) begin
            @(negedge core_clk_in);
            n = n + 8'(output_strobe_out);
        end
    endtask : count_strobes
    initial begin
        rst_in = 1'b1;
        {path_sel_in, sleep_in, ext_filter_in} = 3'b010;
        {prescale_sel_in, m_div_in, charge_pump_sel_in} = 13'h1C11;
        coarse_tune_in = 6'h20;
        @(negedge core_clk_in);
        `CHK({vco_divide_out, cp_current_out, vco_tune_out}, 12'h460)
        `CHK({use_loop_clk_out, loop_enable_out, lock_status_out}, 5'h00)
        repeat (2) @(posedge core_clk_in);
        rst_in <= 1'b0;
        // Ordinary field cases
        for (int i = 0; i < 9; i++) begin
            r = ROWS[i];
            @(posedge core_clk_in);
            {prescale_sel_in, m_div_in, charge_pump_sel_in, ext_filter_in} <= r[17:4];
            coarse_tune_in <= r[12:7];
            repeat (3) @(negedge core_clk_in);
            ratio = r[3:0] * r[14:7];
            `CHK(vco_divide_out, r[3:0])
            `CHK(cp_current_out, r[6:5] == 2'h2 ? 2'h0 : r[6:5])
            `CHK(vco_tune_out, r[12:7])
            `CHK(ratio_ok_out, ratio >= 12'h018 && ratio <= 12'h1E0)
            `CHK(stable_cfg_out, ratio < 12'h078 || r[6:5] == 2'h3 || r[4])
        end
        // Wake the loop, select it, and let it settle
        @(posedge core_clk_in);
        {prescale_sel_in, m_div_in, charge_pump_sel_in} <= 13'h1C11;
        {coarse_tune_in, ext_filter_in, path_sel_in, sleep_in} <= 9'h082;
        wait_lock(3'h3);
        `CHK({use_loop_clk_out, loop_enable_out}, 2'h3)
        count_strobes(40);
        `CHK(n, 8'h0A)
        @(posedge core_clk_in);
        m_div_in <= 8'h08;
        repeat (4) @(negedge core_clk_in);
        count_strobes(40);
        `CHK(n, 8'h05)
        // Mistuned oscillator keeps the loop out of lock
        @(posedge core_clk_in);
        coarse_tune_in <= 6'h08;
        repeat (2) @(negedge core_clk_in);
        `CHK(cfg_changed_out, 1'b1)
        repeat (118) @(negedge core_clk_in);
        `CHK(lock_status_out, 3'h1)
        @(posedge core_clk_in);
        coarse_tune_in <= 6'h3F;
        repeat (120) @(negedge core_clk_in);
        `CHK(lock_status_out, 3'h7)
        // Back to the direct clock, then to sleep
        @(posedge core_clk_in);
        {path_sel_in, coarse_tune_in} <= 7'h20;
        repeat (6) @(negedge core_clk_in);
        count_strobes(20);
        `CHK({use_loop_clk_out, n}, 9'h000)
        @(posedge core_clk_in);
        sleep_in <= 1'b1;
        repeat (6) @(negedge core_clk_in);
        `CHK({loop_enable_out, lock_status_out}, 4'h0)
        tally_and_finish();
    end
endmodule : tb_top
`default_nettype wire
